/* design/pst_pkg.sv */
// Shared constants, register map and types of the power-state controller
package pst_pkg;

	localparam int CLK_MHZ = 40;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int STRAP_SETTLE_NS = 200;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
	// Two synchroniser stages sit between the pin and the sampling point
	localparam int STRAP_WAIT_CYC = STRAP_SETTLE_CYC + 2;
	localparam logic [7:0] RST_DELAY_MS_RST = 8'h10;

	////////////////////////////////////////////////////////////////////////////
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_RST_DELAY = 8'h04;
	localparam logic [7:0] OFS_INT_STAT  = 8'h08;
	localparam logic [7:0] OFS_INT_MASK  = 8'h0c;
	localparam logic [7:0] OFS_STATUS    = 8'h10;

	localparam int CTRL_UNMASK_BIT = 0;
	localparam int NUM_FAULT = 5;
	localparam int NUM_INT = 6;
	localparam int INT_THERMAL_BIT = 0;
	localparam int INT_BUCK_OC_LSB = 1;
	localparam int INT_LONG_PRESS_BIT = 5;
	localparam logic [NUM_FAULT-1:0] INT_MASK_RST = 5'h1f;
	localparam logic [NUM_INT-1:0] INT_STAT_RST = 6'h00;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_AUX1_LSB = 4;
	localparam int STAT_MEM_LSB = 6;
	localparam int STAT_STRAP_DONE_BIT = 8;

	////////////////////////////////////////////////////////////////////////////
	// Default rail voltages in millivolts
	localparam logic [11:0] AUX1_MV_LOW   = 12'h708;
	localparam logic [11:0] AUX1_MV_FLOAT = 12'h9c4;
	localparam logic [11:0] AUX1_MV_HIGH  = 12'hce4;
	localparam logic [11:0] MEM_MV_LOW    = 12'h4b0;
	localparam logic [11:0] MEM_MV_FLOAT  = 12'h546;
	localparam logic [11:0] MEM_MV_HIGH   = 12'h708;

	// Mode input codes, ordered {hold, low power, high performance}
	localparam logic [2:0] MODE_OFF       = 3'h0;
	localparam logic [2:0] MODE_HIBER     = 3'h2;
	localparam logic [2:0] MODE_LOW_PWR   = 3'h6;
	localparam logic [2:0] MODE_ACTIVE    = 3'h4;
	localparam logic [2:0] MODE_HIGH_PERF = 3'h5;

	localparam logic [3:0] BUCK_NONE  = 4'h0;
	localparam logic [3:0] BUCK_ALL   = 4'hf;
	localparam logic [3:0] BUCK_HIBER = 4'ha;

	typedef enum logic [1:0] {STRAP_LOW, STRAP_FLOAT, STRAP_HIGH} pst_strap_t;
	typedef enum logic [1:0] {SP_BIAS_HI, SP_BIAS_LO, SP_DONE} pst_strap_phase_t;
	typedef enum logic [2:0] {
		PS_OFF, PS_SEQ, PS_RST_DLY, PS_HIBER, PS_LOW_PWR, PS_ACTIVE, PS_HIGH_PERF
	} pst_state_t;

endpackage

/* design/pst_sync2.sv */
// Two-flop synchroniser for asynchronous level inputs
module pst_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

/* design/pst_delay_timer.sv */
// Millisecond delay timer: loads on start, done stays high until next start
module pst_delay_timer #(
	parameter int CYC_PER_MS = 40000
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       start_i,
	input  wire logic [7:0] ms_i,
	output logic            done_o
);
	logic [7:0]  ms_q;
	logic [31:0] pre_q;
	logic        run_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_q   <= 8'h00;
			pre_q  <= 32'h0;
			run_q  <= 1'b0;
			done_o <= 1'b0;
		end else if (start_i) begin
			ms_q   <= ms_i;
			pre_q  <= 32'(CYC_PER_MS - 1);
			run_q  <= (ms_i != 8'h00);
			done_o <= (ms_i == 8'h00);
		end else if (run_q) begin
			if (pre_q != 32'h0) begin
				pre_q <= pre_q - 32'h1;
			end else if (ms_q == 8'h01) begin
				run_q  <= 1'b0;
				done_o <= 1'b1;
			end else begin
				ms_q  <= ms_q - 8'h01;
				pre_q <= 32'(CYC_PER_MS - 1);
			end
		end
	end
endmodule

/* design/pst_power_state_ctrl.sv */
// Power-state controller: mode decoding, straps, interrupt and host reset
//
// Function
// - High-performance request reads as zero until software sets the unmask bit.
// - After supply reset the state machine starts in OFF, all rails off.
// - Decode hold/low-power/high-perf into rail enables, load modes and reset.
// - OFF is left only through the power-up sequence; then follow mode inputs.
// - Aux regulator 1 default: low 1.8V, floating 2.5V, high 3.3V.
// - Memory rail default: low 1.2V, floating 1.35V, high 1.8V.
// - Straps latched once after supply rises; later changes ignored.
// - Bias strap pins briefly at start-up so open pins read floating.
// - Interrupt pin pulled low while an unmasked fault is pending.
// - All fault mask bits reset to one.
// - Long-press timeout always raises the interrupt, no mask applies.
// - Release host reset a programmable delay after start-up, default 16 ms.
// - Assert host reset at once on thermal fault or buck overcurrent.
// - Assert host reset when hibernate is entered.
// - If power hold is low when reset would release, turn off instead.
//
// Decided for this implementation: strobed register access and the address map.
module pst_power_state_ctrl
	import pst_pkg::*;
#(
	parameter int CYC_PER_MS_P = CYC_PER_MS
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          power_hold_in_i,
	input  wire logic          low_power_request_i,
	input  wire logic          high_perf_request_i,
	input  wire logic          thermal_fault_i,
	input  wire logic [3:0]    buck_oc_i,
	input  wire logic          long_press_i,
	input  wire logic          start_req_i,
	input  wire logic          seq_done_i,
	input  wire logic          aux1_level_strap_i,
	input  wire logic          mem_rail_level_strap_i,
	output logic               aux1_strap_bias_o,
	output logic               aux1_strap_bias_oe_o,
	output logic               mem_strap_bias_o,
	output logic               mem_strap_bias_oe_o,
	input  wire logic [AW-1:0] reg_addr_i,
	input  wire logic [DW-1:0] reg_wdata_i,
	input  wire logic          reg_wr_i,
	input  wire logic          reg_rd_i,
	output logic      [DW-1:0] reg_rdata_o,
	output logic      [3:0]    buck_en_o,
	output logic      [3:0]    buck_light_o,
	output logic               aux_regulator_1_en_o,
	output logic               aux_regulator_2_en_o,
	output logic      [11:0]   aux1_default_mv_o,
	output logic      [11:0]   mem_default_mv_o,
	output logic               strap_valid_o,
	output logic               host_reset_out_n_o,
	output logic               host_reset_out_oe_o,
	output logic               irq_out_n_o,
	output logic               irq_out_oe_o
);

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// Bias high read, then bias low read; a pin that follows the bias is open
	function automatic pst_strap_t strap_decode(input logic hi, input logic lo);
		pst_strap_t s;
		s = STRAP_FLOAT;
		if (hi && lo) begin
			s = STRAP_HIGH;
		end else if (!hi && !lo) begin
			s = STRAP_LOW;
		end
		return s;
	endfunction

	// Illegal codes keep the current state
	function automatic pst_state_t mode_state(input logic [2:0] m, input pst_state_t cur);
		pst_state_t s;
		s = cur;
		case (m)
			MODE_OFF:       s = PS_OFF;
			MODE_HIBER:     s = PS_HIBER;
			MODE_LOW_PWR:   s = PS_LOW_PWR;
			MODE_ACTIVE:    s = PS_ACTIVE;
			MODE_HIGH_PERF: s = PS_HIGH_PERF;
			default:        s = cur;
		endcase
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [9:0]  sync_s;
	logic        hold_s;
	logic        lp_s;
	logic        hp_s;
	logic        thermal_s;
	logic [3:0]  oc_s;
	logic        aux1_pin_s;
	logic        mem_pin_s;

	pst_sync2 #(.W(10)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({power_hold_in_i, low_power_request_i, high_perf_request_i,
		         thermal_fault_i, buck_oc_i, aux1_level_strap_i,
		         mem_rail_level_strap_i}),
		.q_o   (sync_s)
	);

	assign {hold_s, lp_s, hp_s, thermal_s, oc_s, aux1_pin_s, mem_pin_s} = sync_s;

	////////////////////////////////////////////////////////////////////////////
	// Strap snapshot

	pst_strap_phase_t phase_q;
	logic [7:0]       strap_cnt_q;
	logic             aux1_hi_q;
	logic             mem_hi_q;
	pst_strap_t       aux1_strap_q;
	pst_strap_t       mem_strap_q;
	logic             strap_done_q;
	logic             strap_wait_end;

	assign strap_wait_end = (strap_cnt_q == 8'(STRAP_WAIT_CYC - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q     <= SP_BIAS_HI;
			strap_cnt_q <= 8'h00;
		end else if (phase_q != SP_DONE) begin
			strap_cnt_q <= strap_wait_end ? 8'h00 : strap_cnt_q + 8'h01;
			if (strap_wait_end) begin
				phase_q <= (phase_q == SP_BIAS_HI) ? SP_BIAS_LO : SP_DONE;
			end
		end
	end

	// Frozen once taken; only a supply reset opens the snapshot again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux1_hi_q    <= 1'b0;
			mem_hi_q     <= 1'b0;
			aux1_strap_q <= STRAP_FLOAT;
			mem_strap_q  <= STRAP_FLOAT;
			strap_done_q <= 1'b0;
		end else if (strap_wait_end && phase_q == SP_BIAS_HI) begin
			aux1_hi_q <= aux1_pin_s;
			mem_hi_q  <= mem_pin_s;
		end else if (strap_wait_end && phase_q == SP_BIAS_LO) begin
			aux1_strap_q <= strap_decode(aux1_hi_q, aux1_pin_s);
			mem_strap_q  <= strap_decode(mem_hi_q, mem_pin_s);
			strap_done_q <= 1'b1;
		end
	end

	// Weak bias is driven only while the snapshot is being taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux1_strap_bias_o    <= 1'b1;
			aux1_strap_bias_oe_o <= 1'b1;
			mem_strap_bias_o     <= 1'b1;
			mem_strap_bias_oe_o  <= 1'b1;
		end else begin
			aux1_strap_bias_o    <= (phase_q == SP_BIAS_HI) && !strap_wait_end;
			aux1_strap_bias_oe_o <= !(phase_q == SP_DONE ||
			                         (phase_q == SP_BIAS_LO && strap_wait_end));
			mem_strap_bias_o     <= (phase_q == SP_BIAS_HI) && !strap_wait_end;
			mem_strap_bias_oe_o  <= !(phase_q == SP_DONE ||
			                         (phase_q == SP_BIAS_LO && strap_wait_end));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux1_default_mv_o <= AUX1_MV_FLOAT;
			mem_default_mv_o  <= MEM_MV_FLOAT;
			strap_valid_o     <= 1'b0;
		end else begin
			case (aux1_strap_q)
				STRAP_LOW:  aux1_default_mv_o <= AUX1_MV_LOW;
				STRAP_HIGH: aux1_default_mv_o <= AUX1_MV_HIGH;
				default:    aux1_default_mv_o <= AUX1_MV_FLOAT;
			endcase
			case (mem_strap_q)
				STRAP_LOW:  mem_default_mv_o <= MEM_MV_LOW;
				STRAP_HIGH: mem_default_mv_o <= MEM_MV_HIGH;
				default:    mem_default_mv_o <= MEM_MV_FLOAT;
			endcase
			strap_valid_o <= strap_done_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic                 unmask_q;
	logic [7:0]           rst_dly_ms_q;
	logic [NUM_FAULT-1:0] mask_q;
	logic [NUM_INT-1:0]   stat_q;
	logic [NUM_INT-1:0]   stat_clr;
	logic [NUM_INT-1:0]   events;
	pst_state_t           state_q;
	pst_state_t           state_d;

	assign stat_clr = (reg_wr_i && reg_addr_i == OFS_INT_STAT) ? reg_wdata_i[NUM_INT-1:0] : '0;
	assign events = {long_press_i, oc_s, thermal_s};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unmask_q     <= 1'b0;
			rst_dly_ms_q <= RST_DELAY_MS_RST;
			mask_q       <= INT_MASK_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_CTRL:      unmask_q <= reg_wdata_i[CTRL_UNMASK_BIT];
				OFS_RST_DELAY: rst_dly_ms_q <= reg_wdata_i[7:0];
				OFS_INT_MASK:  mask_q <= reg_wdata_i[NUM_FAULT-1:0];
				default:       ;
			endcase
		end
	end

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= INT_STAT_RST;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | events;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_CTRL:      reg_rdata_o <= {31'h0, unmask_q};
				OFS_RST_DELAY: reg_rdata_o <= {24'h0, rst_dly_ms_q};
				OFS_INT_STAT:  reg_rdata_o <= {26'h0, stat_q};
				OFS_INT_MASK:  reg_rdata_o <= {27'h0, mask_q};
				OFS_STATUS:    reg_rdata_o <= {23'h0, strap_done_q, mem_strap_q,
				                               aux1_strap_q, 1'b0, state_q};
				default:       reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt pin

	logic pend;

	assign pend = (|(stat_q[NUM_FAULT-1:0] & ~mask_q)) || stat_q[INT_LONG_PRESS_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_out_oe_o <= 1'b0;
			irq_out_n_o  <= 1'b1;
		end else begin
			irq_out_oe_o <= pend;
			irq_out_n_o  <= !pend;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power state machine

	logic [2:0] mode;
	logic       fault_s;
	logic       hold_prev_q;
	logic       tmr_start;
	logic       tmr_done;

	assign mode = {hold_s, lp_s, hp_s && unmask_q};
	assign fault_s = thermal_s || (|oc_s);

	pst_delay_timer #(.CYC_PER_MS(CYC_PER_MS_P)) u_rst_tmr (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (tmr_start),
		.ms_i    (rst_dly_ms_q),
		.done_o  (tmr_done)
	);

	always_comb begin
		state_d   = state_q;
		tmr_start = 1'b0;
		case (state_q)
			PS_OFF: begin
				if (strap_done_q && (start_req_i || (hold_s && !hold_prev_q))) begin
					state_d = PS_SEQ;
				end
			end
			PS_SEQ: begin
				if (seq_done_i) begin
					state_d   = PS_RST_DLY;
					tmr_start = 1'b1;
				end
			end
			PS_RST_DLY: begin
				if (tmr_done) begin
					state_d = hold_s ? mode_state(mode, PS_ACTIVE) : PS_OFF;
				end
			end
			PS_HIBER, PS_LOW_PWR, PS_ACTIVE, PS_HIGH_PERF: begin
				state_d = mode_state(mode, state_q);
			end
			default: state_d = PS_OFF;
		endcase
		if (fault_s) begin
			state_d = PS_OFF;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q     <= PS_OFF;
			hold_prev_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			hold_prev_q <= hold_s;
		end
	end

	// Outputs follow the next state so pins and state_q agree in every cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buck_en_o            <= BUCK_NONE;
			buck_light_o         <= BUCK_NONE;
			aux_regulator_1_en_o <= 1'b0;
			aux_regulator_2_en_o <= 1'b0;
			host_reset_out_oe_o  <= 1'b1;
			host_reset_out_n_o   <= 1'b0;
		end else begin
			aux_regulator_2_en_o <= 1'b0;
			case (state_d)
				PS_HIBER: begin
					buck_en_o            <= BUCK_HIBER;
					buck_light_o         <= BUCK_HIBER;
					aux_regulator_1_en_o <= 1'b0;
					host_reset_out_oe_o  <= 1'b1;
					host_reset_out_n_o   <= 1'b0;
				end
				PS_LOW_PWR: begin
					buck_en_o            <= BUCK_ALL;
					buck_light_o         <= BUCK_ALL;
					aux_regulator_1_en_o <= 1'b1;
					host_reset_out_oe_o  <= 1'b0;
					host_reset_out_n_o   <= 1'b1;
				end
				PS_ACTIVE, PS_HIGH_PERF: begin
					buck_en_o            <= BUCK_ALL;
					buck_light_o         <= BUCK_NONE;
					aux_regulator_1_en_o <= 1'b1;
					host_reset_out_oe_o  <= 1'b0;
					host_reset_out_n_o   <= 1'b1;
				end
				PS_SEQ, PS_RST_DLY: begin
					buck_en_o            <= BUCK_ALL;
					buck_light_o         <= BUCK_NONE;
					aux_regulator_1_en_o <= 1'b1;
					host_reset_out_oe_o  <= 1'b1;
					host_reset_out_n_o   <= 1'b0;
				end
				default: begin
					buck_en_o            <= BUCK_NONE;
					buck_light_o         <= BUCK_NONE;
					aux_regulator_1_en_o <= 1'b0;
					host_reset_out_oe_o  <= 1'b1;
					host_reset_out_n_o   <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence seq_dly_expire;
		state_q == PS_RST_DLY && tmr_done && !fault_s;
	endsequence

	sequence seq_reset_release;
		$fell(host_reset_out_oe_o);
	endsequence

	chk_hp_masked: assert property (
		!unmask_q && state_q != PS_HIGH_PERF |=> state_q != PS_HIGH_PERF
	) else $error("high-perf state entered while masked");

	chk_reset_off: assert property (
		$past(rst_i) |-> state_q == PS_OFF && buck_en_o == BUCK_NONE && host_reset_out_oe_o
	) else $error("not off after reset");

	chk_hiber_rails: assert property (
		state_q == PS_HIBER |-> buck_en_o == BUCK_HIBER && buck_light_o == BUCK_HIBER
			&& !aux_regulator_1_en_o && host_reset_out_oe_o
	) else $error("hibernate outputs wrong");

	chk_active_rails: assert property (
		state_q == PS_ACTIVE |-> buck_en_o == BUCK_ALL && buck_light_o == BUCK_NONE
			&& aux_regulator_1_en_o && !host_reset_out_oe_o
	) else $error("active outputs wrong");

	chk_off_exit: assert property (
		state_q == PS_OFF |=> state_q == PS_OFF || state_q == PS_SEQ
	) else $error("off left without power-up");

	chk_strap_frozen: assert property (
		strap_done_q |=> $stable(aux1_strap_q) && $stable(mem_strap_q) && strap_done_q
	) else $error("strap snapshot changed");

	chk_bias_start: assert property (
		$past(rst_i) |-> aux1_strap_bias_oe_o && mem_strap_bias_oe_o ##1 aux1_strap_bias_o[*4]
	) else $error("strap bias not applied");

	chk_irq_unmasked: assert property (
		|(stat_q[NUM_FAULT-1:0] & ~mask_q) |=> irq_out_oe_o && !irq_out_n_o
	) else $error("unmasked fault without interrupt");

	chk_long_press: assert property (
		long_press_i |=> ##1 irq_out_oe_o
	) else $error("long press did not interrupt");

	chk_mask_reset: assert property (
		$past(rst_i) |-> mask_q == INT_MASK_RST
	) else $error("mask not all ones after reset");

	chk_release_timed: assert property (
		seq_reset_release |-> $past(tmr_done) && $past(state_q == PS_RST_DLY)
			|| $past(state_q == PS_HIBER)
	) else $error("reset released without delay");

	chk_fault_reset: assert property (
		fault_s |=> host_reset_out_oe_o && state_q == PS_OFF
	) else $error("fault did not assert reset");

	chk_hold_low_off: assert property (
		seq_dly_expire and !hold_s |=> state_q == PS_OFF && host_reset_out_oe_o
	) else $error("no turn-off with hold low");

endmodule

/* tb/pst_host_model.sv */
// Host processor model: drives the mode pins and watches the host reset line
module pst_host_model
	import pst_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic [2:0] mode_i,
	input  wire logic       hp_allow_i,
	input  wire logic       host_reset_out_oe_i,
	output logic            power_hold_in_o,
	output logic            low_power_request_o,
	output logic            high_perf_request_o,
	output logic            in_reset_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] mode_q = MODE_OFF;

	// Undefined codes are never put on the pins; the last legal one stays
	always_ff @(posedge clk_i) begin
		if (mode_i inside {MODE_OFF, MODE_HIBER, MODE_LOW_PWR, MODE_ACTIVE, MODE_HIGH_PERF}) begin
			mode_q <= mode_i;
		end
	end

	assign power_hold_in_o     = mode_q[2];
	assign low_power_request_o = mode_q[1];
	// Kept low until software has unmasked it, unless a scenario says otherwise
	assign high_perf_request_o = mode_q[0] & hp_allow_i;
	// Line has a pull-up: released means out of reset
	assign in_reset_o          = host_reset_out_oe_i;
endmodule

/* tb/pst_power_state_ctrl_test.sv */
// Self-checking bench of the power-state controller
module pst_power_state_ctrl_test
	import pst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 0, rst_i = 1, thermal_fault_i = 0, long_press_i = 0;
	logic start_req_i = 0, seq_done_i = 0, reg_wr_i = 0, reg_rd_i = 0, hp_allow = 0;
	logic [3:0] buck_oc_i = 4'h0;
	logic [2:0] mode = MODE_OFF;
	logic [1:0] sa = 2'h1, sm = 2'h1;
	logic [AW-1:0] reg_addr_i = 8'h00;
	logic [DW-1:0] reg_wdata_i = 32'h0, reg_rdata_o, rv;
	logic ph, pl, pr, in_rst, a_lvl, m_lvl, a_b, a_oe, m_b, m_oe;
	logic [3:0] buck_en_o, buck_light_o;
	logic [11:0] a_mv, m_mv;
	logic aux1_en, strap_valid, irq_oe;
	logic in_rst_oe, rst_n, irq_n, aux2_en;
	int num_errors = 0, checked = 0;
	logic [11:0] a_tab[3] = '{AUX1_MV_LOW, AUX1_MV_FLOAT, AUX1_MV_HIGH};
	logic [11:0] m_tab[3] = '{MEM_MV_LOW, MEM_MV_FLOAT, MEM_MV_HIGH};

	always #12.5 clk_i = ~clk_i;

	// An open strap pin follows the weak bias, else shows the inverse of it
	assign a_lvl = (sa == 2'h2) | ((sa == 2'h1) & (a_oe ? a_b : ~a_b));
	assign m_lvl = (sm == 2'h2) | ((sm == 2'h1) & (m_oe ? m_b : ~m_b));

	pst_power_state_ctrl #(.CYC_PER_MS_P(4)) pst_power_state_ctrl_inst (
		.clk_i(clk_i), .rst_i(rst_i), .power_hold_in_i(ph), .low_power_request_i(pl),
		.high_perf_request_i(pr), .thermal_fault_i(thermal_fault_i), .buck_oc_i(buck_oc_i),
		.long_press_i(long_press_i), .start_req_i(start_req_i), .seq_done_i(seq_done_i),
		.aux1_level_strap_i(a_lvl), .mem_rail_level_strap_i(m_lvl),
		.aux1_strap_bias_o(a_b), .aux1_strap_bias_oe_o(a_oe), .mem_strap_bias_o(m_b),
		.mem_strap_bias_oe_o(m_oe), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.buck_en_o(buck_en_o), .buck_light_o(buck_light_o), .aux_regulator_1_en_o(aux1_en),
		.aux_regulator_2_en_o(aux2_en), .aux1_default_mv_o(a_mv), .mem_default_mv_o(m_mv),
		.strap_valid_o(strap_valid), .host_reset_out_n_o(rst_n),
		.host_reset_out_oe_o(in_rst_oe), .irq_out_n_o(irq_n), .irq_out_oe_o(irq_oe));

	pst_host_model pst_host_model_inst (
		.clk_i(clk_i), .mode_i(mode), .hp_allow_i(hp_allow), .host_reset_out_oe_i(in_rst_oe),
		.power_hold_in_o(ph), .low_power_request_o(pl), .high_perf_request_o(pr),
		.in_reset_o(in_rst));

	task automatic close_out();
		if (num_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (exp !== got) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 rv = reg_rdata_o;
	endtask

	task automatic outs(logic [3:0] en, logic [3:0] lt, logic rs);
		chk("buck_en", en, buck_en_o);
		chk("buck_light", lt, buck_light_o);
		chk("host_reset", rs, in_rst);
		chk("host_reset_n", !rs, rst_n);
		chk("aux2_en", 0, aux2_en);
	endtask

	task automatic pulse_start();
		@(posedge clk_i);
		start_req_i <= 1'b1;
		@(posedge clk_i);
		start_req_i <= 1'b0;
		cyc(3);
		outs(4'hf, 4'h0, 1'b1);
		chk("aux1_en", 1, aux1_en);
		@(posedge clk_i);
		seq_done_i <= 1'b1;
		@(posedge clk_i);
		seq_done_i <= 1'b0;
	endtask

	// Start-up with hold high: reset released after the delay, ACTIVE decode
	task automatic t_power_up();
		int n;
		mode <= MODE_ACTIVE;
		cyc(4);
		pulse_start();
		n = 0;
		while (in_rst === 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk("rst_delay_ok", 1, n >= 63 && n <= 68);
		outs(4'hf, 4'h0, 1'b0);
	endtask

	task automatic t_modes();
		mode <= MODE_LOW_PWR;
		cyc(6);
		outs(4'hf, 4'hf, 1'b0);
		mode <= MODE_HIBER;
		cyc(6);
		outs(BUCK_HIBER, BUCK_HIBER, 1'b1);
		chk("aux1_hiber", 0, aux1_en);
		mode <= MODE_ACTIVE;
		cyc(6);
		outs(4'hf, 4'h0, 1'b0);
		// Host pin raised on purpose before unmasking
		hp_allow <= 1'b1;
		mode <= MODE_HIGH_PERF;
		cyc(6);
		rd(OFS_STATUS);
		chk("state_masked", PS_ACTIVE, rv[2:0]);
		wr(OFS_CTRL, 32'h1);
		cyc(2);
		rd(OFS_STATUS);
		chk("state_hiperf", PS_HIGH_PERF, rv[2:0]);
		outs(4'hf, 4'h0, 1'b0);
		mode <= MODE_ACTIVE;
		cyc(6);
	endtask

	task automatic t_faults();
		for (int i = 0; i < 2; i++) begin
			// A start request only acts from OFF, so leave the run state first
			mode <= MODE_OFF;
			cyc(6);
			t_power_up();
			if (i == 0) begin
				thermal_fault_i <= 1'b1;
			end else begin
				buck_oc_i <= 4'h4;
			end
			cyc(5);
			outs(4'h0, 4'h0, 1'b1);
			thermal_fault_i <= 1'b0;
			buck_oc_i <= 4'h0;
			cyc(4);
		end
		chk("irq_masked", 0, irq_oe);
		rd(OFS_INT_STAT);
		chk("int_stat", 32'h9, rv);
		wr(OFS_INT_MASK, 32'h1e);
		cyc(2);
		chk("irq_unmasked", 1, irq_oe);
		chk("irq_n_low", 0, irq_n);
		wr(OFS_INT_STAT, 32'h9);
		cyc(2);
		chk("irq_cleared", 0, irq_oe);
		wr(OFS_INT_MASK, 32'h1f);
		@(posedge clk_i);
		long_press_i <= 1'b1;
		@(posedge clk_i);
		long_press_i <= 1'b0;
		cyc(3);
		chk("irq_long_press", 1, irq_oe);
		wr(OFS_INT_STAT, 32'h20);
		cyc(2);
		chk("irq_lp_cleared", 0, irq_oe);
	endtask

	// Hold still low when reset would go: turn off, reset never let go
	task automatic t_hold_low();
		int rel = 0;
		mode <= MODE_OFF;
		cyc(6);
		pulse_start();
		repeat (100) begin
			cyc(1);
			rel += (in_rst !== 1'b1);
		end
		chk("released", 0, rel);
		rd(OFS_STATUS);
		chk("state_off", PS_OFF, rv[2:0]);
		outs(4'h0, 4'h0, 1'b1);
	endtask

	initial begin
		for (int i = 0; i < 3; i++) begin
			sa <= 2'(i);
			sm <= 2'((i + 1) % 3);
			rst_i <= 1'b1;
			repeat (16) @(posedge clk_i);
			rst_i <= 1'b0;
			cyc(1);
			outs(4'h0, 4'h0, 1'b1);
			chk("irq_rst", 0, irq_oe);
			for (int n = 0; n < 100 && strap_valid !== 1'b1; n++) cyc(1);
			chk("strap_valid", 1, strap_valid);
			chk("aux1_mv", a_tab[i], a_mv);
			chk("mem_mv", m_tab[(i + 1) % 3], m_mv);
			sa <= 2'((i + 2) % 3);
			sm <= 2'(i);
			cyc(30);
			chk("aux1_frozen", a_tab[i], a_mv);
			chk("mem_frozen", m_tab[(i + 1) % 3], m_mv);
		end
		rd(OFS_INT_MASK);
		chk("mask_rst", 32'h1f, rv);
		rd(8'h20);
		chk("unmapped", 0, rv);
		t_power_up();
		t_modes();
		t_faults();
		t_hold_low();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		close_out();
	end
endmodule
